// ===== rtl/uxc_ep_decode.sv
// Purpose: Map a protocol endpoint address onto one of seven pipes (0..6)
// Assumes: Address stable while valid
// Notes:   Pipe 0 is the control endpoint, matched only at address 0x00 (not 0x80); result registered
`timescale 1ns/1ps
`default_nettype none
`include "uxc_regs.svh"
module uxc_ep_decode (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  uxc_ep_if.dec     ep
);
  logic       hit_reg, hit_next;
  logic [2:0] pipe_reg, pipe_next;
  logic [`UXC_NUM_EP_PAIRS:0] match;

  // One match line per endpoint number
  genvar g;
  generate
    for (g = 0; g <= `UXC_NUM_EP_PAIRS; g++) begin : gen_match
      if (g == 0) begin : gen_ctl
        assign match[g] = (ep.ep_addr == `UXC_EP0_ADDR);
      end else begin : gen_pair
        assign match[g] = (ep.ep_addr[6:0] == 7'(g));
      end
    end
  endgenerate

  always_comb begin
    hit_next  = 1'b0;
    pipe_next = 3'h0;
    for (int i = 0; i <= `UXC_NUM_EP_PAIRS; i++) begin
      if (ep.ep_valid && match[i]) begin
        hit_next = 1'b1;
        // IN pipes 1..3 sit at indices 4..6, OUT pipes 1..3 at 1..3
        if (i != 0 && ep.ep_addr[`UXC_IN_DIR_BIT]) begin
          pipe_next = 3'(i + `UXC_NUM_EP_PAIRS);
        end else begin
          pipe_next = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      hit_reg  <= 1'b0;
      pipe_reg <= 3'h0;
    end else begin
      hit_reg  <= hit_next;
      pipe_reg <= pipe_next;
    end
  end

  assign ep.ep_hit  = hit_reg;
  assign ep.ep_pipe = pipe_reg;
endmodule
`default_nettype wire

// ===== rtl/uxc_xcvr_ctrl.sv
// Purpose: Transceiver control register, pull-up steering, test drive, line status and endpoint lookup
// Assumes: Register bus and line inputs synchronous to sys_clk_i
// Notes:   Function role only; no host logic exists here
`timescale 1ns/1ps
`default_nettype none
`include "uxc_regs.svh"
module uxc_xcvr_ctrl
  import uxc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_sel_o,
  input  wire logic       vbus_present_i,
  input  wire logic       dplus_level_i,
  input  wire logic       dminus_level_i,
  input  wire logic       diff_rx_i,
  input  wire logic [7:0] token_ep_addr_i,
  input  wire logic       token_valid_i,
  output logic            ep_hit_o,
  output logic      [2:0] ep_pipe_o,
  output logic            full_speed_o,
  output logic            phy_enable_o,
  output logic            pullup_dplus_o,
  output logic            pullup_dminus_o,
  output logic            dplus_out_o,
  output logic            dplus_oe_o,
  output logic            dminus_out_o,
  output logic            dminus_oe_o
);
  logic [4:0]     ctrl_reg, ctrl_next;
  logic [2:0]     stat_reg, stat_next;
  logic [7:0]     rdata_reg, rdata_next;
  logic           sel_reg, sel_next;
  logic           hit_reg, hit_next;
  logic [2:0]     pipe_reg, pipe_next;
  logic [3:0]     steer_reg, steer_next;
  logic [3:0]     test_reg, test_next;
  logic           pullup_en, phy_en, speed;
  uxc_test_mode_t test_mode;
  logic           hit_sel;

  uxc_ep_if ep_bus ();

  assign ep_bus.ep_addr  = token_ep_addr_i;
  assign ep_bus.ep_valid = token_valid_i && phy_en;

  uxc_ep_decode u_ep_decode (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .ep        (ep_bus.dec)
  );

  // ctrl_reg holds bits 7..3 of the register
  assign pullup_en = ctrl_reg[`UXC_BIT_PULLUP_EN - `UXC_BIT_TEST_LO];
  assign phy_en    = ctrl_reg[`UXC_BIT_PHY_EN - `UXC_BIT_TEST_LO];
  assign speed     = ctrl_reg[`UXC_BIT_SPEED - `UXC_BIT_TEST_LO];
  assign test_mode = uxc_test_mode_t'(ctrl_reg[1:0]);
  assign hit_sel   = (sfr_addr_i == `UXC_XCVR_CTRL_ADDR);

  // Register write path; status bits are never stored from the bus
  always_comb begin
    ctrl_next = ctrl_reg;
    if (sfr_wr_i && hit_sel) begin
      ctrl_next = sfr_wdata_i[7:3];
    end
  end

  // Live line status; differential value held at zero while suspended
  always_comb begin
    stat_next = {diff_rx_i && phy_en, dplus_level_i, dminus_level_i};
  end

  always_comb begin
    rdata_next = 8'h00;
    sel_next   = sfr_rd_i && hit_sel;
    if (sfr_rd_i && hit_sel) begin
      rdata_next = {ctrl_reg, stat_reg};
    end
  end

  always_comb begin
    hit_next  = ep_bus.ep_hit;
    pipe_next = ep_bus.ep_pipe;
  end

  // Steering: {full_speed, phy_en, pu_dp, pu_dm}; speed picks the line, bus power gates it
  always_comb begin
    logic pu_on;
    pu_on      = pullup_en && vbus_present_i;
    steer_next = {speed, phy_en, pu_on && speed, pu_on && !speed};
  end

  // Test drive: {dp_out, dp_oe, dm_out, dm_oe}; pins driven only while the transceiver is on
  always_comb begin
    logic dp_v, dm_v, oe;
    dp_v = 1'b0;
    dm_v = 1'b0;
    oe   = phy_en && (test_mode != UXC_TEST_NORMAL);
    case (test_mode)
      UXC_TEST_NORMAL: begin
        dp_v = 1'b0;
        dm_v = 1'b0;
      end
      UXC_TEST_DIFF1: begin
        dp_v = 1'b1;
        dm_v = 1'b0;
      end
      UXC_TEST_DIFF0: begin
        dp_v = 1'b0;
        dm_v = 1'b1;
      end
      UXC_TEST_SE0: begin
        dp_v = 1'b0;
        dm_v = 1'b0;
      end
      default: begin
        dp_v = 1'b0;
        dm_v = 1'b0;
      end
    endcase
    test_next = {dp_v, oe, dm_v, oe};
  end

  // Control field: the only state software writes
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= 5'(`UXC_XCVR_CTRL_RESET >> `UXC_BIT_TEST_LO);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Line status sampled every cycle, so a read returns levels one cycle old
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Read return stands for one cycle after the read
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
      sel_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      sel_reg   <= sel_next;
    end
  end

  // Second stage of the endpoint lookup
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      hit_reg  <= 1'b0;
      pipe_reg <= 3'h0;
    end else begin
      hit_reg  <= hit_next;
      pipe_reg <= pipe_next;
    end
  end

  // Pull-up steering outputs
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      steer_reg <= 4'h0;
    end else begin
      steer_reg <= steer_next;
    end
  end

  // Forced line drive outputs
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      test_reg <= 4'h0;
    end else begin
      test_reg <= test_next;
    end
  end

  assign sfr_rdata_o     = rdata_reg;
  assign sfr_sel_o       = sel_reg;
  assign ep_hit_o        = hit_reg;
  assign ep_pipe_o       = pipe_reg;
  assign full_speed_o    = steer_reg[3];
  assign phy_enable_o    = steer_reg[2];
  assign pullup_dplus_o  = steer_reg[1];
  assign pullup_dminus_o = steer_reg[0];
  assign dplus_out_o     = test_reg[3];
  assign dplus_oe_o      = test_reg[2];
  assign dminus_out_o    = test_reg[1];
  assign dminus_oe_o     = test_reg[0];
endmodule
`default_nettype wire

// ===== shared/uxc_ep_if.sv
// Purpose: Endpoint lookup carrier between the control block and its decoder
// Assumes: One clock
// Notes:   Token endpoint address in, pipe hit out
`timescale 1ns/1ps
`default_nettype none
interface uxc_ep_if;
  logic [7:0] ep_addr;
  logic       ep_valid;
  logic       ep_hit;
  logic [2:0] ep_pipe;
  modport ctrl (output ep_addr, output ep_valid, input ep_hit, input ep_pipe);
  modport dec  (input ep_addr, input ep_valid, output ep_hit, output ep_pipe);
endinterface
`default_nettype wire

// ===== shared/uxc_pkg.sv
// Purpose: Types of the transceiver control block
// Assumes: Nothing beyond the register header
// Notes:   Test mode encoding follows the two-bit test field
package uxc_pkg;
  typedef enum logic [1:0] {
    UXC_TEST_NORMAL = 2'h0,
    UXC_TEST_DIFF1  = 2'h1,
    UXC_TEST_DIFF0  = 2'h2,
    UXC_TEST_SE0    = 2'h3
  } uxc_test_mode_t;
endpackage

// ===== shared/uxc_regs.svh
// Purpose: Register offsets, field positions and reset values of the transceiver control block
// Assumes: 8-bit special-function register bus
// Notes:   Definitions only
`ifndef UXC_REGS_SVH
`define UXC_REGS_SVH
`define UXC_XCVR_CTRL_ADDR    8'hd7
`define UXC_XCVR_CTRL_RESET   8'h00
`define UXC_BIT_PULLUP_EN     7
`define UXC_BIT_PHY_EN        6
`define UXC_BIT_SPEED         5
`define UXC_BIT_TEST_HI       4
`define UXC_BIT_TEST_LO       3
`define UXC_BIT_DIFF_RX       2
`define UXC_BIT_DPLUS         1
`define UXC_BIT_DMINUS        0
`define UXC_EP0_ADDR          8'h00
`define UXC_IN_DIR_BIT        7
`define UXC_NUM_EP_PAIRS      3
`define UXC_NUM_PIPES         8
`endif

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the transceiver control block
// Assumes: Host line model on the far side
// Notes:   Inputs change on rising edges by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, vbus = 1'b0, tv = 1'b0;
  logic [7:0] addr = 8'hd7, wd = 8'h00, ta = 8'h00, rdat;
  logic [2:0] pipe;
  logic       sel, hit, fs, phy, pud, pum, dpo, dpe, dmo, dme, dp, dm, dif;
  int         failures = 0, samples_checked = 0, cyc = 0;
  always #5 clk = ~clk;
  uxc_xcvr_ctrl u_dut (.sys_clk_i(clk), .resetn_i(rstn), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .sfr_sel_o(sel), .vbus_present_i(vbus), .dplus_level_i(dp),
    .dminus_level_i(dm), .diff_rx_i(dif), .token_ep_addr_i(ta), .token_valid_i(tv), .ep_hit_o(hit),
    .ep_pipe_o(pipe), .full_speed_o(fs), .phy_enable_o(phy), .pullup_dplus_o(pud), .pullup_dminus_o(pum),
    .dplus_out_o(dpo), .dplus_oe_o(dpe), .dminus_out_o(dmo), .dminus_oe_o(dme));
  uxc_host_model u_host (.pu_dp_i(pud), .pu_dm_i(pum), .dp_out_i(dpo), .dp_oe_i(dpe), .dm_out_i(dmo),
    .dm_oe_i(dme), .dp_o(dp), .dm_o(dm), .diff_o(dif));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wrt(input logic [7:0] d);
    wr <= 1'b1;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rdt(input logic [7:0] a, input logic [8:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= 8'hd7;
    #1 chk({sel, rdat}, exp);
    @(posedge clk);
  endtask
  task automatic tkt(input logic [7:0] a, input logic [3:0] exp);
    tv <= 1'b1;
    ta <= a;
    @(posedge clk);
    tv <= 1'b0;
    @(posedge clk);
    #1 chk({5'h00, hit, pipe}, {5'h00, exp});
    @(posedge clk);
  endtask
  task automatic s_reset;
    rdt(8'hd7, 9'h100);
    rdt(8'h96, 9'h000);
    chk({5'h00, fs, phy, pud, pum}, 9'h000);
  endtask
  task automatic s_pullup;
    vbus <= 1'b1;
    wrt(8'h67);
    rdt(8'hd7, 9'h160);
    wrt(8'he0);
    chk({5'h00, fs, phy, pud, pum}, 9'h00e);
    rdt(8'hd7, 9'h1e6);
    wrt(8'hc0);
    chk({6'h00, fs, pud, pum}, 9'h001);
    rdt(8'hd7, 9'h1c1);
    vbus <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, pud, pum}, 9'h000);
    vbus <= 1'b1;
    wrt(8'ha0);
    rdt(8'hd7, 9'h1a2);
    wrt(8'h60);
    chk({7'h00, pud, pum}, 9'h000);
  endtask
  task automatic s_test;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wrt({3'h2, m, 3'h7});
      chk({5'h00, dpe, dpo, dme, dmo}, {5'h00, m != 2'h0, m == 2'h1, m != 2'h0, m == 2'h2});
      rdt(8'hd7, {4'ha, m, m == 2'h1, m == 2'h1, m == 2'h2});
    end
    wrt(8'h18);
    chk({7'h00, dpe, dme}, 9'h000);
  endtask
  task automatic s_ep;
    logic [11:0] t [10] = '{12'h008, 12'h019, 12'h02a, 12'h03b, 12'h81c, 12'h82d, 12'h83e, 12'h800, 12'h040, 12'h840};
    wrt(8'h40);
    foreach (t[i]) tkt(t[i][11:4], t[i][3:0]);
    wrt(8'h00);
    tkt(8'h01, 4'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    s_reset();
    s_pullup();
    s_test();
    s_ep();
    end_sim();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      end_sim();
    end
  end
endmodule
`default_nettype wire

// ===== tb/uxc_host_model.sv
// Purpose: Far-side line model: host pull-downs plus device pull-ups and forced drive
// Assumes: Released lines settle low through the host pull-downs
// Notes:   Differential one is D+ high with D- low
`timescale 1ns/1ps
`default_nettype none
module uxc_host_model (
  input  wire logic pu_dp_i,
  input  wire logic pu_dm_i,
  input  wire logic dp_out_i,
  input  wire logic dp_oe_i,
  input  wire logic dm_out_i,
  input  wire logic dm_oe_i,
  output logic      dp_o,
  output logic      dm_o,
  output logic      diff_o
);
  assign dp_o   = dp_oe_i ? dp_out_i : pu_dp_i;
  assign dm_o   = dm_oe_i ? dm_out_i : pu_dm_i;
  assign diff_o = dp_o & ~dm_o;
endmodule
`default_nettype wire

// ===== tb/uxc_xcvr_ctrl_sva.sv
// Purpose: Port checks of the transceiver control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into uxc_xcvr_ctrl
`timescale 1ns/1ps
`default_nettype none
module uxc_xcvr_ctrl_sva (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_rd_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_sel_o,
  input wire logic       vbus_present_i,
  input wire logic       dplus_level_i,
  input wire logic       dminus_level_i,
  input wire logic [7:0] token_ep_addr_i,
  input wire logic       token_valid_i,
  input wire logic       ep_hit_o,
  input wire logic [2:0] ep_pipe_o,
  input wire logic       full_speed_o,
  input wire logic       phy_enable_o,
  input wire logic       pullup_dplus_o,
  input wire logic       pullup_dminus_o,
  input wire logic       dplus_out_o,
  input wire logic       dplus_oe_o,
  input wire logic       dminus_out_o,
  input wire logic       dminus_oe_o
);
  logic       map_ok;
  logic [2:0] exp_pipe;
  assign map_ok   = token_ep_addr_i[6:2] == 5'h00 && (token_ep_addr_i[1:0] != 2'h0 || !token_ep_addr_i[7]);
  assign exp_pipe = {1'b0, token_ep_addr_i[1:0]} + (token_ep_addr_i[7] ? 3'h3 : 3'h0);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rst; $rose(resetn_i) |-> !sfr_sel_o && !ep_hit_o && !phy_enable_o && !pullup_dplus_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_dp; pullup_dplus_o |-> full_speed_o; endproperty
  a_dp: assert property (p_dp) else $error("D+ pull-up at low speed");
  property p_dm; pullup_dminus_o |-> !full_speed_o; endproperty
  a_dm: assert property (p_dm) else $error("D- pull-up at full speed");
  property p_vb; pullup_dplus_o || pullup_dminus_o |-> $past(vbus_present_i); endproperty
  a_vb: assert property (p_vb) else $error("pull-up without bus power");
  property p_oe; !phy_enable_o |-> !dplus_oe_o && !dminus_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("drive while suspended");
  property p_tst; dplus_oe_o |-> dminus_oe_o && !(dplus_out_o && dminus_out_o); endproperty
  a_tst: assert property (p_tst) else $error("bad forced drive");
  property p_rd;
    sfr_rd_i && sfr_addr_i == 8'hd7 && $stable({dplus_level_i, dminus_level_i})
    |=> sfr_sel_o && sfr_rdata_o[1:0] == $past({dplus_level_i, dminus_level_i}, 2);
  endproperty
  a_rd: assert property (p_rd) else $error("line status read wrong");
  property p_hit; token_valid_i && phy_enable_o && !$past(sfr_wr_i) && map_ok |-> ##2 ep_hit_o && ep_pipe_o == $past(exp_pipe, 2); endproperty
  a_hit: assert property (p_hit) else $error("endpoint lookup wrong");
  property p_miss; token_valid_i && !map_ok |-> ##2 !ep_hit_o && ep_pipe_o == 3'h0; endproperty
  a_miss: assert property (p_miss) else $error("unmapped endpoint hit");
endmodule
bind uxc_xcvr_ctrl uxc_xcvr_ctrl_sva u_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o), .sfr_sel_o(sfr_sel_o),
  .vbus_present_i(vbus_present_i), .dplus_level_i(dplus_level_i), .dminus_level_i(dminus_level_i),
  .token_ep_addr_i(token_ep_addr_i), .token_valid_i(token_valid_i), .ep_hit_o(ep_hit_o), .ep_pipe_o(ep_pipe_o),
  .full_speed_o(full_speed_o), .phy_enable_o(phy_enable_o), .pullup_dplus_o(pullup_dplus_o),
  .pullup_dminus_o(pullup_dminus_o), .dplus_out_o(dplus_out_o), .dplus_oe_o(dplus_oe_o),
  .dminus_out_o(dminus_out_o), .dminus_oe_o(dminus_oe_o));
`default_nettype wire
